// ### src/prc_pkg.sv
// Constants for the pulse reference and position error counter block.
// Assumes a single 25 MHz core clock and synchronous configuration ports.
package prc_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ            = 25_000_000;
	localparam int unsigned SERVO_ON_WAIT_MS  = 40;
	localparam int unsigned SERVO_ON_WAIT_CYC = CLK_HZ / 1000 * SERVO_ON_WAIT_MS;
	localparam int unsigned LD_MAX_PPS        = 4_000_000;
	localparam int unsigned OC_MAX_PPS        = 200_000;
	localparam int unsigned QUAD_MAX_PPS      = 1_000_000;
	localparam int unsigned LD_MIN_PER_CYC    = CLK_HZ / LD_MAX_PPS;

	// ****************************************************************
	// Configuration field codes
	// ****************************************************************
	localparam logic [3:0] PF_SIGN_POS = 4'h0;
	localparam logic [3:0] PF_FR_POS   = 4'h1;
	localparam logic [3:0] PF_QUAD_X1  = 4'h2;
	localparam logic [3:0] PF_QUAD_X2  = 4'h3;
	localparam logic [3:0] PF_QUAD_X4  = 4'h4;
	localparam logic [3:0] PF_SIGN_NEG = 4'h5;
	localparam logic [3:0] PF_FR_NEG   = 4'h6;
	localparam logic [1:0] CF_LVL_ON   = 2'h0;
	localparam logic [1:0] CF_RISE     = 2'h1;
	localparam logic [1:0] CF_LVL_OFF  = 2'h2;
	localparam logic [1:0] CF_FALL     = 2'h3;
	localparam logic [1:0] AC_BASEBLK  = 2'h0;
	localparam logic [1:0] AC_CLR_ONLY = 2'h1;
	localparam logic [1:0] AC_ALARM    = 2'h2;

	// ****************************************************************
	// Gear and feedback scaling
	// ****************************************************************
	localparam int unsigned GEAR_W       = 31;
	localparam logic [30:0] GEAR_NUM_DEF = 31'h0000_0004;
	localparam logic [30:0] GEAR_DEN_DEF = 31'h0000_0001;
	localparam logic [43:0] RATIO_MIN_INV = 44'h000_0000_03E8;
	localparam logic [43:0] RATIO_MAX     = 44'h000_0000_0FA0;
	localparam int unsigned SCALE_FRAC_BITS = 8;
	localparam logic [15:0] PITCH_TO_NM   = 16'h000A;
	localparam logic [15:0] PITCH_DEF     = 16'h07D0;

endpackage

// ### src/prc_top.sv
// Pulse train reference decoder, electronic gear and position error counter.
// Assumes every input is synchronous to core_clk and held stable between pulses.
`timescale 1ns/1ps

module prc_top
	import prc_pkg::*;
#(
	parameter int unsigned ERR_W    = 32,
	parameter int unsigned WAIT_CYC = SERVO_ON_WAIT_CYC
)
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// Reference pulse pins
	input  wire logic               ref_pulse_in,
	input  wire logic               ref_sign_in,
	input  wire logic               counter_clear_in,
	// Drive state
	input  wire logic               servo_on_in,
	input  wire logic               alarm_in,
	input  wire logic               restart_in,
	// Configuration, taken at restart
	input  wire logic [3:0]         pulse_form_field,
	input  wire logic [1:0]         clear_form_field,
	input  wire logic [1:0]         auto_clear_field,
	input  wire logic [GEAR_W-1:0]  gear_numerator,
	input  wire logic [GEAR_W-1:0]  gear_denominator,
	input  wire logic [15:0]        scale_pitch_setting,
	// Scale feedback in pitch/256 units
	input  wire logic               fb_step_in,
	input  wire logic               fb_fwd_in,
	// Status
	output logic signed [ERR_W-1:0] err_count_r,
	output logic                    pos_loop_en,
	output logic                    param_err_r,
	output logic                    gear_busy,
	output logic [15:0]             fb_res_nm_q8_r
);

	typedef enum logic [0:0] {PRC_IDLE, PRC_DIV} prc_state_t;

	// ****************************************************************
	// State
	// ****************************************************************
	prc_state_t              st_r, st_nxt;
	logic [3:0]              pf_r, pf_nxt;
	logic [1:0]              cf_r, cf_nxt, ac_r, ac_nxt;
	logic [GEAR_W-1:0]       num_r, num_nxt, den_r, den_nxt;
	logic [GEAR_W-1:0]       quo_r, quo_nxt, rem_r, rem_nxt, acc_r, acc_nxt;
	logic [GEAR_W:0]         part_r, part_nxt;
	logic [4:0]              bit_r, bit_nxt;
	logic                    pa_r, pb_r, clr_in_r;
	logic [19:0]             wait_r, wait_nxt;
	logic signed [ERR_W-1:0] err_nxt;
	logic                    perr_nxt;
	logic [15:0]             fres_nxt;

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic       a, b, a_rise, a_fall, b_edge, q_fwd, cnt_en, cnt_fwd;
	logic       clr_now, alarm_any, ready;
	logic [43:0] num_w, den_w;
	logic [GEAR_W:0] trial;
	logic [GEAR_W:0] acc_sum;

	// Negative logic forms invert both pins so one decoder serves all.
	always_comb
	begin
		a       = (pf_r == PF_SIGN_NEG || pf_r == PF_FR_NEG) ? ~ref_pulse_in : ref_pulse_in;
		b       = (pf_r == PF_SIGN_NEG || pf_r == PF_FR_NEG) ? ~ref_sign_in : ref_sign_in;
		a_rise  = a & ~pa_r;
		a_fall  = ~a & pa_r;
		b_edge  = b ^ pb_r;
		q_fwd   = a ^ pb_r;
		cnt_en  = 1'b0;
		cnt_fwd = 1'b1;
		case (pf_r)
			PF_SIGN_POS, PF_SIGN_NEG:
			begin
				cnt_en  = a_rise;
				cnt_fwd = b;
			end
			PF_FR_POS, PF_FR_NEG:
			begin
				// Forward pulses win if both pins rise in one cycle.
				cnt_en  = a_rise | (b & ~pb_r);
				cnt_fwd = a_rise;
			end
			PF_QUAD_X1:
			begin
				cnt_en  = a_rise;
				cnt_fwd = q_fwd;
			end
			PF_QUAD_X2:
			begin
				cnt_en  = a_rise | a_fall;
				cnt_fwd = q_fwd;
			end
			PF_QUAD_X4:
			begin
				cnt_en  = a_rise | a_fall | b_edge;
				cnt_fwd = (a_rise | a_fall) ? q_fwd : ~(a ^ b);
			end
			default:
			begin
				cnt_en  = 1'b0;
				cnt_fwd = 1'b1;
			end
		endcase
	end

	// Clear request from pin and drive state, using the latched forms.
	always_comb
	begin
		alarm_any = alarm_in | param_err_r;
		case (cf_r)
			CF_LVL_ON:  clr_now = counter_clear_in;
			CF_RISE:    clr_now = counter_clear_in & ~clr_in_r;
			CF_LVL_OFF: clr_now = ~counter_clear_in;
			CF_FALL:    clr_now = ~counter_clear_in & clr_in_r;
			default:    clr_now = 1'b0;
		endcase
		case (ac_r)
			AC_BASEBLK:  clr_now = clr_now | ~servo_on_in | alarm_any;
			AC_ALARM:    clr_now = clr_now | alarm_any;
			default:     clr_now = clr_now;
		endcase
		ready       = (st_r == PRC_IDLE) && servo_on_in && (wait_r == 20'h00000) && !param_err_r;
		pos_loop_en = ready && !clr_now;
		gear_busy   = (st_r == PRC_DIV);
	end

	// ****************************************************************
	// Next state: restart latch, divider, gear and error counter
	// ****************************************************************
	always_comb
	begin
		st_nxt   = st_r;
		pf_nxt   = pf_r;
		cf_nxt   = cf_r;
		ac_nxt   = ac_r;
		num_nxt  = num_r;
		den_nxt  = den_r;
		quo_nxt  = quo_r;
		rem_nxt  = rem_r;
		acc_nxt  = acc_r;
		part_nxt = part_r;
		bit_nxt  = bit_r;
		perr_nxt = param_err_r;
		fres_nxt = fb_res_nm_q8_r;
		err_nxt  = err_count_r;
		wait_nxt = wait_r;
		num_w    = {13'h0000, num_r};
		den_w    = {13'h0000, den_r};
		trial    = {part_r[GEAR_W-1:0], quo_r[GEAR_W-1]};
		acc_sum  = {1'b0, acc_r} + {1'b0, rem_r};
		// Pulses before the settle time are dropped, matching the host wait.
		if (!servo_on_in)
			wait_nxt = WAIT_CYC[19:0];
		else if (wait_r != 20'h00000)
			wait_nxt = wait_r - 20'h00001;
		if (restart_in)
		begin
			// New settings land only here, so a running axis never sees them.
			pf_nxt   = pulse_form_field;
			cf_nxt   = clear_form_field;
			ac_nxt   = auto_clear_field;
			num_nxt  = gear_numerator;
			den_nxt  = gear_denominator;
			quo_nxt  = gear_numerator;
			part_nxt = '0;
			acc_nxt  = '0;
			bit_nxt  = 5'h00;
			err_nxt  = '0;
			fres_nxt = 16'(scale_pitch_setting * PITCH_TO_NM);
			st_nxt   = PRC_DIV;
		end
		else if (st_r == PRC_DIV)
		begin
			// Restoring divide, one quotient bit per cycle, 31 cycles.
			if (trial >= {1'b0, den_r})
			begin
				part_nxt = trial - {1'b0, den_r};
				quo_nxt  = {quo_r[GEAR_W-2:0], 1'b1};
			end
			else
			begin
				part_nxt = trial;
				quo_nxt  = {quo_r[GEAR_W-2:0], 1'b0};
			end
			bit_nxt = bit_r + 5'h01;
			if (bit_r == 5'(GEAR_W - 1))
			begin
				rem_nxt  = part_nxt[GEAR_W-1:0];
				st_nxt   = PRC_IDLE;
				perr_nxt = (num_w * RATIO_MIN_INV < den_w) || (num_w > den_w * RATIO_MAX);
			end
		end
		else if (clr_now)
		begin
			// Only a real clear zeroes; an axis merely held off keeps its error.
			err_nxt = '0;
			acc_nxt = '0;
		end
		else if (ready)
		begin
			// Whole part of the ratio each pulse, plus a carried fraction.
			if (cnt_en)
			begin
				if (acc_sum >= {1'b0, den_r})
				begin
					acc_nxt = GEAR_W'(acc_sum - {1'b0, den_r});
					err_nxt = cnt_fwd ? err_nxt + ERR_W'(quo_r) + 1 : err_nxt - ERR_W'(quo_r) - 1;
				end
				else
				begin
					acc_nxt = acc_sum[GEAR_W-1:0];
					err_nxt = cnt_fwd ? err_nxt + ERR_W'(quo_r) : err_nxt - ERR_W'(quo_r);
				end
			end
			if (fb_step_in)
				err_nxt = fb_fwd_in ? err_nxt - 1 : err_nxt + 1;
		end
	end

	// Register stage; defaults give ratio 4 so no divide is needed at reset.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_r           <= PRC_IDLE;
			pf_r           <= PF_SIGN_POS;
			cf_r           <= CF_LVL_ON;
			ac_r           <= AC_BASEBLK;
			num_r          <= GEAR_NUM_DEF;
			den_r          <= GEAR_DEN_DEF;
			quo_r          <= GEAR_NUM_DEF;
			rem_r          <= '0;
			acc_r          <= '0;
			part_r         <= '0;
			bit_r          <= 5'h00;
			param_err_r    <= 1'b0;
			fb_res_nm_q8_r <= 16'(PITCH_DEF * PITCH_TO_NM);
			err_count_r    <= '0;
			wait_r         <= WAIT_CYC[19:0];
			pa_r           <= 1'b0;
			pb_r           <= 1'b0;
			clr_in_r       <= 1'b0;
		end
		else
		begin
			st_r           <= st_nxt;
			pf_r           <= pf_nxt;
			cf_r           <= cf_nxt;
			ac_r           <= ac_nxt;
			num_r          <= num_nxt;
			den_r          <= den_nxt;
			quo_r          <= quo_nxt;
			rem_r          <= rem_nxt;
			acc_r          <= acc_nxt;
			part_r         <= part_nxt;
			bit_r          <= bit_nxt;
			param_err_r    <= perr_nxt;
			fb_res_nm_q8_r <= fres_nxt;
			err_count_r    <= err_nxt;
			wait_r         <= wait_nxt;
			pa_r           <= a;
			pb_r           <= b;
			clr_in_r       <= counter_clear_in;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_clr_req;
		clr_now && st_r == PRC_IDLE && !restart_in;
	endsequence
	property p_clear_zero;
		@(posedge core_clk) disable iff (!rst_n) s_clr_req |=> err_count_r == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("Counter not zeroed on clear.");
	property p_level_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(cf_r == CF_LVL_ON && counter_clear_in && st_r == PRC_IDLE) |-> !pos_loop_en;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("Level clear let loop run.");
	property p_baseblock;
		@(posedge core_clk) disable iff (!rst_n)
		(ac_r == AC_BASEBLK && !servo_on_in && !restart_in) |=> err_count_r == '0;
	endproperty
	a_baseblock: assert property (p_baseblock) else $error("Baseblock did not clear.");
	property p_sign_fwd;
		@(posedge core_clk) disable iff (!rst_n)
		(pf_r == PF_SIGN_POS && pos_loop_en && a_rise && b && !fb_step_in && !restart_in
			&& quo_r != '0)
		|=> $signed(err_count_r) > $signed($past(err_count_r));
	endproperty
	a_sign_fwd: assert property (p_sign_fwd) else $error("Forward sign did not add.");
	property p_sign_rev;
		@(posedge core_clk) disable iff (!rst_n)
		(pf_r == PF_SIGN_POS && pos_loop_en && a_rise && !b && !fb_step_in && !restart_in
			&& quo_r != '0)
		|=> $signed(err_count_r) < $signed($past(err_count_r));
	endproperty
	a_sign_rev: assert property (p_sign_rev) else $error("Reverse sign did not subtract.");
	// Helper count of divide cycles, kept apart from the divider's own bit counter.
	logic [5:0] div_cyc_r, div_cyc_nxt;
	always_comb
	begin
		div_cyc_nxt = (st_r == PRC_DIV && !restart_in) ? div_cyc_r + 6'h01 : 6'h00;
	end
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			div_cyc_r <= 6'h00;
		else
			div_cyc_r <= div_cyc_nxt;
	end
	property p_div_len;
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == PRC_DIV && !restart_in)
			|-> (div_cyc_r == 6'(GEAR_W - 1)) == (st_nxt == PRC_IDLE);
	endproperty
	a_div_len: assert property (p_div_len) else $error("Gear divide not done in 31 cycles.");
	property p_ratio_hi;
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == PRC_IDLE && {13'h0000, num_r} > {13'h0000, den_r} * RATIO_MAX) |-> param_err_r;
	endproperty
	a_ratio_hi: assert property (p_ratio_hi) else $error("Ratio above limit not flagged.");
	property p_err_stop;
		@(posedge core_clk) disable iff (!rst_n) param_err_r |-> !pos_loop_en;
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("Loop ran with bad ratio.");
	property p_x1_step;
		@(posedge core_clk) disable iff (!rst_n)
		(pf_r == PF_QUAD_X1 && pos_loop_en && a_fall && !fb_step_in && !restart_in)
		|=> err_count_r == $past(err_count_r);
	endproperty
	a_x1_step: assert property (p_x1_step) else $error("x1 counted a falling edge.");

endmodule

// ### tb/prc_host_model.sv
// Host controller model driving the reference pulse and clear pins.
// Assumes tasks are called from one process just after a clock edge.
`timescale 1ns/1ps
module prc_host_model
(
	// Host clock
	input  wire logic core_clk,
	// Pins toward the drive
	output logic      ref_pulse_in,
	output logic      ref_sign_in,
	output logic      counter_clear_in
);
	// Line drivers hold every pin at a defined level from time zero.
	initial
	begin
		ref_pulse_in = 1'b0;
		ref_sign_in = 1'b0;
		counter_clear_in = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Sets all three pin levels; no pulse is implied.
	task automatic idle(input logic a, input logic b, input logic c);
		ref_pulse_in <= a;
		ref_sign_in <= b;
		counter_clear_in <= c;
		// One settle cycle keeps the next task from driving a pin in this step.
		hold(1);
	endtask

	// Four cycles a level stays inside 4 Mpps and the minimum pulse width.
	task automatic pulse(input logic on_sign, input logic neg, input int n);
		repeat (n)
		begin
			if (on_sign) ref_sign_in <= !neg; else ref_pulse_in <= !neg;
			hold(4);
			if (on_sign) ref_sign_in <= neg; else ref_pulse_in <= neg;
			hold(4);
		end
	endtask

	// Seven cycles a quarter keeps the phase rate under 1 Mpps.
	task automatic quad(input logic fwd, input int n);
		logic [1:0] ph [4];
		ph = '{2'b10, 2'b11, 2'b01, 2'b00};
		repeat (n)
			foreach (ph[i])
			begin
				if (fwd) {ref_pulse_in, ref_sign_in} <= ph[i];
				else {ref_sign_in, ref_pulse_in} <= ph[i];
				hold(7);
			end
	endtask

	// Level clears are held 250 us, edge clears 20 us at 25 MHz.
	task automatic clear(input logic v, input logic lvl);
		counter_clear_in <= v;
		hold(lvl ? 6250 : 500);
	endtask
endmodule

// ### tb/prc_top_tb_top.sv
// Self-checking bench for the pulse reference and error counter block.
// Assumes the host model drives the pins and the bench drives the rest.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module prc_top_tb_top import prc_pkg::*;;
	// A short wait keeps the run brief; expectations use it too.
	localparam int unsigned WAIT = 8;
	logic               core_clk, rst_n, servo_on_in, alarm_in, restart_in;
	logic               fb_step_in, fb_fwd_in, pos_loop_en, param_err_r, gear_busy;
	logic               ref_pulse_in, ref_sign_in, counter_clear_in;
	logic [3:0]         pf;
	logic [1:0]         cf, ac;
	logic [GEAR_W-1:0]  gn, gd;
	logic [15:0]        pitch, fb_res_nm_q8_r;
	logic signed [31:0] err_count_r;
	int                 miscompares, num_checks, cyc;

	prc_top #(.ERR_W(32), .WAIT_CYC(WAIT)) prc_top_i
	(
		.core_clk, .rst_n, .ref_pulse_in, .ref_sign_in, .counter_clear_in,
		.servo_on_in, .alarm_in, .restart_in, .pulse_form_field(pf),
		.clear_form_field(cf), .auto_clear_field(ac), .gear_numerator(gn),
		.gear_denominator(gd), .scale_pitch_setting(pitch), .fb_step_in, .fb_fwd_in,
		.err_count_r, .pos_loop_en, .param_err_r, .gear_busy, .fb_res_nm_q8_r
	);
	prc_host_model prc_host_model_i
	(
		.core_clk, .ref_pulse_in, .ref_sign_in, .counter_clear_in
	);

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// The ceiling is nearly three times the expected run, so a hang ends the test.
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Restart latches the fields; the divide runs 31 cycles after it.
	task automatic restart(input logic [3:0] f, input logic [1:0] c, a, input int num, den);
		pf <= f;
		cf <= c;
		ac <= a;
		gn <= GEAR_W'(num);
		gd <= GEAR_W'(den);
		restart_in <= 1'b1;
		tick(1);
		restart_in <= 1'b0;
		tick(3);
		`CHK(gear_busy, 1'b1)
		tick(31);
		`CHK(gear_busy, 1'b0)
		`CHK(err_count_r, 32'sh0)
		tick(WAIT + 2);
	endtask

	task automatic t_reset();
		`CHK(err_count_r, 32'sh0)
		`CHK(pos_loop_en, 1'b0)
		`CHK(fb_res_nm_q8_r, 16'h4E20)
		servo_on_in <= 1'b1;
		prc_host_model_i.pulse(1'b0, 1'b0, 1);
		`CHK(err_count_r, 32'sh0)
		tick(WAIT);
	endtask

	// Forward twice then reverse three times; fr picks the pin pair form.
	task automatic t_form(input logic [3:0] f, input logic neg, input logic fr);
		prc_host_model_i.idle(neg, neg, 1'b0);
		restart(f, CF_LVL_ON, AC_BASEBLK, 4, 1);
		prc_host_model_i.idle(neg, fr ? neg : !neg, 1'b0);
		prc_host_model_i.pulse(1'b0, neg, 2);
		`CHK(err_count_r, 32'sh8)
		prc_host_model_i.idle(neg, neg, 1'b0);
		prc_host_model_i.pulse(fr, neg, 3);
		`CHK(err_count_r, -32'sd4)
	endtask

	task automatic t_quad(input logic [3:0] f, input int mult);
		prc_host_model_i.idle(1'b0, 1'b0, 1'b0);
		restart(f, CF_LVL_ON, AC_BASEBLK, 4, 1);
		prc_host_model_i.quad(1'b1, 2);
		`CHK(err_count_r, 32'(8 * mult))
		prc_host_model_i.quad(1'b0, 1);
		`CHK(err_count_r, 32'(4 * mult))
	endtask

	// A 3/2 ratio makes the fractional carry show on every second pulse.
	task automatic t_gear();
		pitch <= 16'h0064;
		restart(PF_SIGN_POS, CF_LVL_ON, AC_BASEBLK, 3, 2);
		`CHK(fb_res_nm_q8_r, 16'h03E8)
		prc_host_model_i.idle(1'b0, 1'b1, 1'b0);
		prc_host_model_i.pulse(1'b0, 1'b0, 2);
		`CHK(err_count_r, 32'sh3)
		gn <= GEAR_W'(7);
		prc_host_model_i.pulse(1'b0, 1'b0, 2);
		`CHK(err_count_r, 32'sh6)
		fb_step_in <= 1'b1;
		tick(1);
		fb_step_in <= 1'b0;
		tick(2);
		`CHK(err_count_r, 32'sh5)
		fb_fwd_in <= 1'b0;
		fb_step_in <= 1'b1;
		tick(1);
		fb_step_in <= 1'b0;
		fb_fwd_in <= 1'b1;
		tick(2);
		`CHK(err_count_r, 32'sh6)
	endtask

	task automatic t_ratio();
		int num [4] = '{4001, 4000, 1, 1};
		int den [4] = '{1, 1, 1001, 1000};
		foreach (num[i])
		begin
			restart(PF_SIGN_POS, CF_LVL_ON, AC_CLR_ONLY, num[i], den[i]);
			`CHK(param_err_r, 1'(i % 2 == 0))
			`CHK(pos_loop_en, 1'(i % 2))
		end
	endtask

	// Level forms block pulses while held; edge forms clear once.
	task automatic t_clear(input logic [1:0] c);
		logic lvl;
		lvl = !c[0];
		prc_host_model_i.idle(1'b0, 1'b1, c[1]);
		restart(PF_SIGN_POS, c, AC_CLR_ONLY, 4, 1);
		cf <= ~c;
		prc_host_model_i.pulse(1'b0, 1'b0, 2);
		`CHK(err_count_r, 32'sh8)
		prc_host_model_i.clear(!c[1], lvl);
		`CHK(err_count_r, 32'sh0)
		`CHK(pos_loop_en, !lvl)
		prc_host_model_i.pulse(1'b0, 1'b0, 1);
		`CHK(err_count_r, lvl ? 32'sh0 : 32'sh4)
		prc_host_model_i.clear(c[1], lvl);
		prc_host_model_i.pulse(1'b0, 1'b0, 1);
		`CHK(err_count_r, lvl ? 32'sh4 : 32'sh8)
	endtask

	task automatic t_auto(input logic [1:0] a);
		prc_host_model_i.idle(1'b0, 1'b1, 1'b0);
		restart(PF_SIGN_POS, CF_LVL_ON, a, 4, 1);
		ac <= AC_CLR_ONLY;
		prc_host_model_i.pulse(1'b0, 1'b0, 2);
		servo_on_in <= 1'b0;
		tick(3);
		`CHK(err_count_r, (a == AC_BASEBLK) ? 32'sh0 : 32'sh8)
		servo_on_in <= 1'b1;
		tick(WAIT + 4);
		prc_host_model_i.pulse(1'b0, 1'b0, 1);
		alarm_in <= 1'b1;
		tick(3);
		`CHK(err_count_r, (a == AC_CLR_ONLY) ? 32'shC : 32'sh0)
		alarm_in <= 1'b0;
		tick(2);
	endtask

	// Main sequence: reset for 16 cycles, then each scenario in turn.
	initial
	begin
		rst_n = 1'b0;
		servo_on_in = 1'b0;
		alarm_in = 1'b0;
		restart_in = 1'b0;
		fb_step_in = 1'b0;
		fb_fwd_in = 1'b1;
		pf = PF_QUAD_X4;
		cf = CF_FALL;
		ac = AC_ALARM;
		gn = GEAR_W'(9);
		gd = GEAR_W'(2);
		pitch = 16'h07D0;
		cyc = 0;
		tick(16);
		rst_n <= 1'b1;
		tick(2);
		t_reset();
		t_form(PF_SIGN_POS, 1'b0, 1'b0);
		t_form(PF_FR_POS, 1'b0, 1'b1);
		t_form(PF_SIGN_NEG, 1'b1, 1'b0);
		t_form(PF_FR_NEG, 1'b1, 1'b1);
		t_quad(PF_QUAD_X1, 1);
		t_quad(PF_QUAD_X2, 2);
		t_quad(PF_QUAD_X4, 4);
		t_gear();
		t_ratio();
		for (int c = 0; c < 4; c++)
			t_clear(2'(c));
		for (int a = 0; a < 3; a++)
			t_auto(2'(a));
		give_verdict();
	end
endmodule
